//--- rtl/i2cm_master.sv
// What this block does
// - Acknowledge enable pulls SCL low and drives the acknowledge value on SDA.
// - Acknowledge: one period, release SCL, wait high, one period, SCL low.
// - Acknowledge end clears its enable, stops baud counter, goes inactive.
// - Buffer write during acknowledge or stop sets write collision, buffer kept.
// - Stop: SDA low, reload on SDA low, release SCL, SDA one period later.
// - SDA seen high with SCL high during stop sets stop-detected.
// - One period after stop detect, clear stop bit and set port flag.
// - While asleep, completed byte wakes the processor if interrupt enabled.
// - Reset or disable aborts transfers and clears start and stop detected.
// - Stop seen on busy bus raises port flag when interrupt enabled.
// - Released SDA read low with SCL high in a data bit or acknowledge sequence sets bus collision, goes idle.
// - Byte collision halts shift, clears buffer full, releases lines.
// - Sequence collision aborts it, releases lines, clears its enable bit.
// - After collision, next buffer write sends from the first bit.
// - SDA or SCL low when start begins aborts with bus collision.
// - Start loads counter once SDA high; SCL low while SDA high collides.
// - SDA low in first start count asserts SDA early; else at count end.
// - Repeated start releases SCL after count; SDA low at SCL high collides.
// - Repeated start high phase: SDA fall fine, SCL fall collides.
// - Both high at timeout: SDA low, reload, then SCL low regardless.
// - Each baud period reloads from low seven reload bits until rollover.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "i2cm_defs.svh"

module i2cm_master (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sleep_mode,
  output logic wake_req
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;

  always_ff @(posedge core_clk) begin
    sda_s1_reg <= sda_in;
    sda_s2_reg <= sda_s1_reg;
    sda_d_reg <= sda_s2_reg;
    scl_s1_reg <= scl_in;
    scl_s2_reg <= scl_s1_reg;
    scl_d_reg <= scl_s2_reg;
  end

  wire sda = sda_s2_reg;
  wire scl = scl_s2_reg;
  wire bus_start = scl && scl_d_reg && sda_d_reg && !sda;
  wire bus_stop = scl && scl_d_reg && !sda_d_reg && sda;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  i2cm_pkg::i2cm_state_t st_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic en_reg, ien_reg, ackval_reg;
  logic sen_reg, rsen_reg, pen_reg, ack_sequence_enable_reg;
  logic bf_reg, sdet_reg, pdet_reg, ackstat_reg;
  logic irq_reg, bcol_reg, write_collision_flag_reg;
  logic [7:0] buf_reg, shift_reg;
  logic [3:0] bit_reg;
  logic [6:0] baud_reg;
  logic sda_low_reg, scl_low_reg, load_reg, wake_reg;

  i2cm_baud_if bif ();
  assign bif.run = (st_reg != i2cm_pkg::I2CM_IDLE);
  assign bif.load = load_reg;
  assign bif.reload = baud_reg;
  wire tick = bif.tick;

  i2cm_baud #(
    .W(`I2CM_BAUD_W)
  ) u_baud (
    .core_clk(core_clk),
    .reset(reset),
    .bif(bif)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  wire take = (avs_read || avs_write) && ack_reg;
  wire wr = take && avs_write;
  wire wr_ctrl = wr && hit(avs_address, `I2CM_OFS_CTRL);
  wire wr_flag = wr && hit(avs_address, `I2CM_OFS_FLAG);
  wire wr_buf = wr && hit(avs_address, `I2CM_OFS_BUF);
  wire rd_buf = take && avs_read && hit(avs_address, `I2CM_OFS_BUF);
  wire idle = (st_reg == i2cm_pkg::I2CM_IDLE);
  // No queueing: sequence bits accepted only while inactive
  wire cmd_ok = wr_ctrl && idle && en_reg;
  wire go_sen = cmd_ok && avs_writedata[`I2CM_CTRL_START];
  wire go_rsen = cmd_ok && avs_writedata[`I2CM_CTRL_RSTART] && !go_sen;
  wire go_pen = cmd_ok && avs_writedata[`I2CM_CTRL_STOP] && !go_sen && !go_rsen;
  wire go_ack = cmd_ok && avs_writedata[`I2CM_CTRL_ACKSEQ] && !go_sen && !go_rsen
                && !go_pen;
  // Buffer is refused while any sequence or byte is in flight
  wire buf_ok = wr_buf && idle && en_reg && !go_sen;
  wire write_collision_flag_set = wr_buf && !buf_ok;

  wire [31:0] ctrl_rd = {24'h000000, en_reg, 1'b0, ackval_reg, ack_sequence_enable_reg, 1'b0,
                         pen_reg, rsen_reg, sen_reg};
  wire [31:0] stat_rd = {25'h0000000, ackstat_reg, 1'b0, pdet_reg, sdet_reg, 2'b00,
                         bf_reg};
  wire [31:0] flag_rd = {29'h00000000, write_collision_flag_reg, bcol_reg, irq_reg};
  wire [31:0] rd_mux =
    hit(avs_address, `I2CM_OFS_CTRL) ? ctrl_rd :
    hit(avs_address, `I2CM_OFS_STAT) ? stat_rd :
    hit(avs_address, `I2CM_OFS_FLAG) ? flag_rd :
    hit(avs_address, `I2CM_OFS_BUF) ? {24'h000000, buf_reg} :
    hit(avs_address, `I2CM_OFS_BAUD) ? {25'h0000000, baud_reg} :
    hit(avs_address, `I2CM_OFS_IEN) ? {31'h00000000, ien_reg} : 32'h00000000;

  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = sda_low_reg;
  assign scl_oe = scl_low_reg;
  assign wake_req = wake_reg;

  // ----------------------------------------------------------------
  // Arbitration checks
  // ----------------------------------------------------------------
  wire c_s0 = (st_reg == i2cm_pkg::I2CM_S_CHK) && (!sda || !scl);
  wire c_s1 = (st_reg == i2cm_pkg::I2CM_S_HI) && sda && !scl;
  wire c_r1 = (st_reg == i2cm_pkg::I2CM_R_REL) && scl && !sda;
  wire c_r2 = (st_reg == i2cm_pkg::I2CM_R_HI) && !scl && sda;
  wire c_tx = (st_reg == i2cm_pkg::I2CM_T_HI) && scl && !sda_low_reg && !sda
              && (bit_reg != `I2CM_ACK_BIT);
  wire c_ak = (st_reg == i2cm_pkg::I2CM_A_HI) && scl && !sda_low_reg && !sda;
  wire c_p = (st_reg == i2cm_pkg::I2CM_P_REL) && tick && !scl;
  wire col = c_s0 || c_s1 || c_r1 || c_r2 || c_tx || c_ak || c_p;

  // Hardware sets win over software clears in the same cycle
  wire irq_ev = (tick && (st_reg == i2cm_pkg::I2CM_S_LO || st_reg == i2cm_pkg::I2CM_R_SDA
                || st_reg == i2cm_pkg::I2CM_P_END))
                || (tick && st_reg == i2cm_pkg::I2CM_T_HI && bit_reg == `I2CM_ACK_BIT)
                || (bus_stop && ien_reg);
  wire byte_done = tick && st_reg == i2cm_pkg::I2CM_T_HI && bit_reg == `I2CM_ACK_BIT;

  // ----------------------------------------------------------------
  // Software registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      en_reg <= 1'b0;
      ien_reg <= 1'b0;
      ackval_reg <= 1'b0;
      baud_reg <= `I2CM_BAUD_RST;
      irq_reg <= 1'b0;
      bcol_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      buf_reg <= 8'h00;
      wake_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if ((avs_read || avs_write) && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
      if (wr_ctrl) begin
        en_reg <= avs_writedata[`I2CM_CTRL_ENABLE];
        ackval_reg <= avs_writedata[`I2CM_CTRL_ACKVAL];
      end
      if (wr && hit(avs_address, `I2CM_OFS_BAUD)) begin
        baud_reg <= avs_writedata[6:0];
      end
      if (wr && hit(avs_address, `I2CM_OFS_IEN)) begin
        ien_reg <= avs_writedata[0];
      end
      if (buf_ok) begin
        buf_reg <= avs_writedata[7:0];
      end
      irq_reg <= irq_ev || (irq_reg && !(wr_flag && avs_writedata[`I2CM_FLAG_IRQ]));
      bcol_reg <= col || (bcol_reg && !(wr_flag && avs_writedata[`I2CM_FLAG_BCOL]));
      write_collision_flag_reg <= write_collision_flag_set || (write_collision_flag_reg && !(wr_flag && avs_writedata[`I2CM_FLAG_WRITE_COLLISION_FLAG]));
      wake_reg <= sleep_mode && ien_reg && byte_done;
    end
  end

  // ----------------------------------------------------------------
  // Bus condition detectors
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || !en_reg) begin
      sdet_reg <= 1'b0;
      pdet_reg <= 1'b0;
    end else if (bus_start) begin
      sdet_reg <= 1'b1;
      pdet_reg <= 1'b0;
    end else if (bus_stop) begin
      sdet_reg <= 1'b0;
      pdet_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || !en_reg || col) begin
      // Collision or disable: abort, free both lines, drop enables
      st_reg <= i2cm_pkg::I2CM_IDLE;
      sen_reg <= 1'b0;
      rsen_reg <= 1'b0;
      pen_reg <= 1'b0;
      ack_sequence_enable_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      bf_reg <= 1'b0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      load_reg <= 1'b0;
      if (reset) begin
        ackstat_reg <= 1'b0;
      end
    end else begin
      load_reg <= 1'b0;
      if (rd_buf) begin
        bf_reg <= 1'b0;
      end
      case (st_reg)
        i2cm_pkg::I2CM_IDLE: begin
          if (go_sen) begin
            sen_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_S_CHK;
          end else if (go_rsen) begin
            rsen_reg <= 1'b1;
            scl_low_reg <= 1'b1;
            sda_low_reg <= 1'b0;
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_R_LO;
          end else if (go_pen) begin
            pen_reg <= 1'b1;
            sda_low_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_P_LO;
          end else if (go_ack) begin
            ack_sequence_enable_reg <= 1'b1;
            scl_low_reg <= 1'b1;
            sda_low_reg <= !avs_writedata[`I2CM_CTRL_ACKVAL];
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_A_LO;
          end else if (buf_ok) begin
            bf_reg <= 1'b1;
            shift_reg <= avs_writedata[7:0];
            bit_reg <= 4'h0;
            scl_low_reg <= 1'b1;
            sda_low_reg <= !avs_writedata[7];
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_T_LO;
          end
        end
        i2cm_pkg::I2CM_S_CHK: begin
          load_reg <= 1'b1;
          st_reg <= i2cm_pkg::I2CM_S_HI;
        end
        i2cm_pkg::I2CM_S_HI: begin
          if (!sda || tick) begin
            sda_low_reg <= 1'b1;
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_S_LO;
          end
        end
        i2cm_pkg::I2CM_S_LO: begin
          if (tick) begin
            scl_low_reg <= 1'b1;
            sen_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_IDLE;
          end
        end
        i2cm_pkg::I2CM_R_LO: begin
          if (tick && sda) begin
            scl_low_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_R_REL;
          end
        end
        i2cm_pkg::I2CM_R_REL: begin
          load_reg <= 1'b1;
          if (scl) begin
            st_reg <= i2cm_pkg::I2CM_R_HI;
          end
        end
        i2cm_pkg::I2CM_R_HI: begin
          if (tick && scl && sda) begin
            sda_low_reg <= 1'b1;
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_R_SDA;
          end
        end
        i2cm_pkg::I2CM_R_SDA: begin
          if (tick) begin
            scl_low_reg <= 1'b1;
            rsen_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_IDLE;
          end
        end
        i2cm_pkg::I2CM_T_LO: begin
          if (tick) begin
            scl_low_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_T_HI;
          end
        end
        i2cm_pkg::I2CM_T_HI: begin
          // Hold the count while a slave stretches SCL
          load_reg <= !scl;
          if (tick) begin
            scl_low_reg <= 1'b1;
            if (bit_reg == `I2CM_ACK_BIT) begin
              ackstat_reg <= sda;
              sda_low_reg <= 1'b0;
              st_reg <= i2cm_pkg::I2CM_IDLE;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
              sda_low_reg <= (bit_reg != `I2CM_LAST_DATA_BIT) && !shift_reg[6];
              if (bit_reg == `I2CM_LAST_DATA_BIT) begin
                bf_reg <= 1'b0;
              end
              load_reg <= 1'b1;
              st_reg <= i2cm_pkg::I2CM_T_LO;
            end
          end
        end
        i2cm_pkg::I2CM_A_LO: begin
          if (tick) begin
            scl_low_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_A_HI;
          end
        end
        i2cm_pkg::I2CM_A_HI: begin
          load_reg <= !scl;
          if (tick) begin
            scl_low_reg <= 1'b1;
            ack_sequence_enable_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_IDLE;
          end
        end
        i2cm_pkg::I2CM_P_LO: begin
          if (!sda) begin
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_P_CNT;
          end
        end
        i2cm_pkg::I2CM_P_CNT: begin
          if (tick) begin
            scl_low_reg <= 1'b0;
            load_reg <= 1'b1;
            st_reg <= i2cm_pkg::I2CM_P_REL;
          end
        end
        i2cm_pkg::I2CM_P_REL: begin
          // Period starts once SCL is seen high, so stretching is no collision
          load_reg <= !scl;
          if (tick) begin
            sda_low_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_P_SDA;
          end
        end
        i2cm_pkg::I2CM_P_SDA: begin
          load_reg <= 1'b1;
          if (sda && scl) begin
            st_reg <= i2cm_pkg::I2CM_P_END;
          end
        end
        i2cm_pkg::I2CM_P_END: begin
          if (tick) begin
            pen_reg <= 1'b0;
            st_reg <= i2cm_pkg::I2CM_IDLE;
          end
        end
        default: begin
          st_reg <= i2cm_pkg::I2CM_IDLE;
        end
      endcase
    end
  end

  // Software arbitration readiness is judged from sdet/pdet
endmodule

//--- rtl/i2cm_defs.svh
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define I2CM_OFS_CTRL 5'h00
`define I2CM_OFS_STAT 5'h04
`define I2CM_OFS_FLAG 5'h08
`define I2CM_OFS_BUF 5'h0c
`define I2CM_OFS_BAUD 5'h10
`define I2CM_OFS_IEN 5'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define I2CM_CTRL_START 0
`define I2CM_CTRL_RSTART 1
`define I2CM_CTRL_STOP 2
`define I2CM_CTRL_ACKSEQ 4
`define I2CM_CTRL_ACKVAL 5
`define I2CM_CTRL_ENABLE 7
`define I2CM_STAT_BF 0
`define I2CM_STAT_START 3
`define I2CM_STAT_STOP 4
`define I2CM_STAT_ACKSTAT 6
`define I2CM_FLAG_IRQ 0
`define I2CM_FLAG_BCOL 1
`define I2CM_FLAG_WRITE_COLLISION_FLAG 2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define I2CM_BAUD_RST 7'h04
`define I2CM_BAUD_W 7
`define I2CM_ACK_BIT 4'h8
`define I2CM_LAST_DATA_BIT 4'h7

`endif

//--- rtl/i2cm_pkg.sv
package i2cm_pkg;

  // One-hot sequencer states
  typedef enum logic [16:0] {
    I2CM_IDLE = 17'h00001,
    I2CM_S_CHK = 17'h00002,
    I2CM_S_HI = 17'h00004,
    I2CM_S_LO = 17'h00008,
    I2CM_R_LO = 17'h00010,
    I2CM_R_REL = 17'h00020,
    I2CM_R_HI = 17'h00040,
    I2CM_R_SDA = 17'h00080,
    I2CM_T_LO = 17'h00100,
    I2CM_T_HI = 17'h00200,
    I2CM_A_LO = 17'h00400,
    I2CM_A_HI = 17'h00800,
    I2CM_P_LO = 17'h01000,
    I2CM_P_CNT = 17'h02000,
    I2CM_P_REL = 17'h04000,
    I2CM_P_SDA = 17'h08000,
    I2CM_P_END = 17'h10000
  } i2cm_state_t;

endpackage

//--- rtl/i2cm_baud_if.sv
`timescale 1ns/1ps
`include "i2cm_defs.svh"

interface i2cm_baud_if;
  logic run;
  logic load;
  logic [`I2CM_BAUD_W-1:0] reload;
  logic tick;
  modport gen (input run, input load, input reload, output tick);
  modport user (output run, output load, output reload, input tick);
endinterface

//--- rtl/i2cm_baud.sv
`timescale 1ns/1ps
`include "i2cm_defs.svh"

module i2cm_baud #(
  parameter int W = `I2CM_BAUD_W
) (
  input wire logic core_clk,
  input wire logic reset,
  i2cm_baud_if.gen bif
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire roll = (cnt_reg == '0);

  // Reload on load or rollover, so one period is reload+1 cycles
  assign cnt_next = (bif.load || roll) ? bif.reload[W-1:0] : cnt_reg - 1'b1;
  assign bif.tick = bif.run && !bif.load && roll;

  always_ff @(posedge core_clk) begin
    if (reset || !bif.run) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

//--- tb/i2cm_master_chk.sv
`timescale 1ns/1ps

module i2cm_master_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sleep_mode,
  input wire logic wake_req
);
  logic [1:0] seen_reg;
  wire wr_ok = avs_write && !avs_waitrequest;
  wire rd_flag = avs_read && !avs_waitrequest && avs_address == 5'h08;
  wire wr_ctrl = wr_ok && avs_address == 5'h00;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Collision bits last read, less what software cleared since
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seen_reg <= 2'h0;
    end else if (wr_ok && avs_address == 5'h08) begin
      seen_reg <= seen_reg & ~avs_writedata[2:1];
    end else if (rd_flag) begin
      seen_reg <= avs_readdata[2:1];
    end
  end

  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("access answered in first cycle");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one cycle");
  open_drain_a: assert property (!sda_out && !scl_out)
    else $error("line driven high");
  reset_idle_a: assert property (
    disable iff (1'b0) reset |=> !sda_oe && !scl_oe && !wake_req)
    else $error("line or wake active after reset");
  wake_cause_a: assert property (
    wake_req |-> $past(sleep_mode) && !$past(wake_req))
    else $error("wake without sleep or too long");
  disable_rel_a: assert property (
    wr_ctrl && !avs_writedata[7] |-> ##[1:4] !sda_oe && !scl_oe)
    else $error("lines held after disable");
  start_abort_a: assert property (
    wr_ctrl && avs_writedata[0] && avs_writedata[7] && !sda_oe && !scl_oe
    && !sda_in && !$past(sda_in) |=> (!sda_oe && !scl_oe) [*3])
    else $error("start driven on a low line");
  col_sticky_a: assert property (
    rd_flag |-> (avs_readdata[2:1] & seen_reg) == seen_reg)
    else $error("collision flag lost");
endmodule

//--- tb/i2cm_bus_sim.sv
`timescale 1ns/1ps

module i2cm_bus_sim (
  input wire logic core_clk,
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic rival_sda_low,
  input wire logic rival_clk_en,
  input wire logic [3:0] stretch,
  output logic sda_in,
  output logic scl_in
);
  logic rival_clk = 1'b1;
  logic scl_oe_q = 1'b0;
  logic [3:0] hold = 4'h0;

  // ----
  // Rival master clock, idle high outside its frames
  // ----
  initial begin
    #3;
    forever #40 rival_clk = rival_clk_en ? ~rival_clk : 1'b1;
  end

  // Slave holds SCL low after each release
  always @(posedge core_clk) begin
    scl_oe_q <= scl_oe;
    if (scl_oe_q && !scl_oe) begin
      hold <= stretch;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end

  // Pull-ups: a released line reads high
  assign sda_in = !(sda_oe || rival_sda_low);
  assign scl_in = !(scl_oe || hold != 4'h0 || (scl_oe_q && stretch != 4'h0) || !rival_clk);
endmodule

//--- tb/i2cm_master_test.sv
`timescale 1ns/1ps

module i2cm_master_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic scl_in;
  logic scl_out;
  logic scl_oe;
  logic sleep_mode = 1'b0;
  logic wake_req;
  logic rival_sda_low = 1'b0;
  logic rival_clk_en = 1'b0;
  logic [3:0] stretch = 4'h0;
  logic [31:0] seed = 32'h8c4d;
  logic [31:0] q;
  logic [31:0] kept;
  logic [31:0] baud;
  int n_errors = 0;
  int checks = 0;
  int wakes = 0;

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (wake_req === 1'b1) begin
      wakes <= wakes + 1;
    end
  end

  i2cm_master i_dut (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sleep_mode(sleep_mode),
    .wake_req(wake_req)
  );

  i2cm_bus_sim i_bus (
    .core_clk(core_clk), .sda_oe(sda_oe), .scl_oe(scl_oe), .rival_sda_low(rival_sda_low),
    .rival_clk_en(rival_clk_en), .stretch(stretch), .sda_in(sda_in), .scl_in(scl_in)
  );

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // SDA is pulled for an acknowledge, released for a refusal
  function automatic logic [31:0] ack_pull(input logic ackval);
    return {31'h0, !ackval};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic fail(input string w);
    n_errors++;
    $display("[FAIL] %0t %s", $time, w);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
    checks++;
    if (got !== exp) begin
      fail($sformatf("%s got %h exp %h", w, got, exp));
    end
  endtask

  task automatic give_up(input string w);
    fail({w, " timed out"});
    report_and_stop();
  endtask

  // Avalon access: held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) begin
        break;
      end
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 16) begin
      give_up("bus");
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string w);
    bus(1'b0, a, 32'h0);
    check(q & m, e, w);
  endtask

  task automatic poll(input logic [4:0] a, input int n, input logic v);
    for (int i = 0; i < 2000; i++) begin
      bus(1'b0, a, 32'h0);
      if (q[n] === v) begin
        checks++;
        return;
      end
    end
    give_up("poll");
  endtask

  task automatic wait_line(input logic clk_line, input logic v);
    for (int i = 0; i < 2000; i++) begin
      @(posedge core_clk);
      if ((clk_line ? scl_oe : sda_oe) === v) begin
        return;
      end
    end
    give_up("line");
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd(5'h00, 32'hffffffff, 32'h0, "ctrl reset");
    rd(5'h04, 32'hffffffff, 32'h0, "stat reset");
    rd(5'h1c, 32'hffffffff, 32'h0, "unmapped");
    bus(1'b1, 5'h1c, 32'hffffffff);
    baud = (rnd() % 32'h5) + 32'h2;
    bus(1'b1, 5'h10, baud);
    rd(5'h10, 32'hffffffff, baud, "baud");
    bus(1'b1, 5'h14, 32'h1);
    bus(1'b1, 5'h00, 32'h80);
    for (int k = 0; k < 2; k++) begin
      stretch <= 4'(rnd());
      bus(1'b0, 5'h0c, 32'h0);
      kept = q & 32'hff;
      bus(1'b1, 5'h00, 32'h90 | (k << 5));
      bus(1'b1, 5'h0c, rnd() & 32'hff);
      check({31'h0, sda_oe}, ack_pull(k[0]), "ack sda");
      poll(5'h00, 4, 1'b0);
      check({31'h0, scl_oe}, 32'h1, "ack end scl");
      rd(5'h08, 32'h4, 32'h4, "write_collision_flag");
      rd(5'h0c, 32'hff, kept, "buffer kept");
      bus(1'b1, 5'h08, 32'h7);
    end
    bus(1'b1, 5'h0c, (rnd() & 32'hff) | 32'h80);
    rival_sda_low <= 1'b1;
    poll(5'h08, 1, 1'b1);
    rival_sda_low <= 1'b0;
    rd(5'h04, 32'h1, 32'h0, "bf cleared");
    check({30'h0, sda_oe, scl_oe}, 32'h0, "released");
    rd(5'h08, 32'h2, 32'h2, "bcol kept");
    bus(1'b1, 5'h08, 32'h7);
    sleep_mode <= 1'b1;
    bus(1'b1, 5'h0c, rnd() & 32'h7f);
    wait_line(1'b1, 1'b1);
    wait_line(1'b1, 1'b0);
    check({31'h0, sda_oe}, 32'h1, "first bit");
    for (int i = 0; i < 3000 && wakes == 0; i++) @(posedge core_clk);
    check(32'(wakes), 32'h1, "wake");
    sleep_mode <= 1'b0;
    rd(5'h04, 32'h41, 32'h40, "nack");
    bus(1'b1, 5'h08, 32'h7);
    bus(1'b1, 5'h00, 32'h84);
    bus(1'b1, 5'h0c, 32'ha5);
    check({30'h0, sda_oe, scl_oe}, 32'h3, "stop sda low");
    poll(5'h00, 2, 1'b0);
    rd(5'h04, 32'h10, 32'h10, "stop seen");
    rd(5'h08, 32'h5, 32'h5, "irq write_collision_flag");
    check({30'h0, sda_oe, scl_oe}, 32'h0, "stop released");
    bus(1'b1, 5'h08, 32'h7);
    // Long period so the rival clock surely falls inside the start count
    bus(1'b1, 5'h10, 32'h7f);
    rival_clk_en <= 1'b1;
    bus(1'b1, 5'h00, 32'h81);
    poll(5'h08, 1, 1'b1);
    rival_clk_en <= 1'b0;
    rd(5'h00, 32'h1, 32'h0, "start cleared");
    repeat (12) @(posedge core_clk);
    bus(1'b1, 5'h08, 32'h7);
    rival_sda_low <= 1'b1;
    bus(1'b1, 5'h00, 32'h81);
    poll(5'h08, 1, 1'b1);
    bus(1'b1, 5'h08, 32'h7);
    rival_sda_low <= 1'b0;
    poll(5'h08, 0, 1'b1);
    bus(1'b1, 5'h00, 32'h0);
    rd(5'h04, 32'h18, 32'h0, "detects cleared");
    bus(1'b1, 5'h00, 32'h80);
    bus(1'b1, 5'h00, 32'h90);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    check({30'h0, sda_oe, scl_oe}, 32'h0, "reset abort");
    rd(5'h00, 32'hffffffff, 32'h0, "ctrl after reset");
    rd(5'h10, 32'hffffffff, 32'h4, "baud after reset");
    report_and_stop();
  end
endmodule

bind i2cm_master i2cm_master_chk i_chk (
  .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sleep_mode(sleep_mode),
  .wake_req(wake_req)
);
